// *** ipas_mem_model.sv ***
// Memory model behind the reference ports
`timescale 1ns/1ns
`default_nettype none
module ipas_mem_model (
  // Byte address and read data
  input wire logic [23:0] addr,
  output logic [15:0] rdata
);
  // Data derived from address bits 15:0, so a wrong low word of the address shows
  assign rdata = addr[15:0] ^ 16'h5a5a;
endmodule : ipas_mem_model
`default_nettype wire

// *** ipas_pkg.sv ***
// Package: constants and types for the index pointer autostep unit
package ipas_pkg;
  // Register offsets
  localparam logic [15:0] IPAS_PORT_A_OFS = 16'h0010;
  localparam logic [15:0] IPAS_PORT_B_OFS = 16'h0016;
  localparam logic [15:0] IPAS_PTR_A_OFS = 16'h1fc0;
  localparam logic [15:0] IPAS_PTR_B_OFS = 16'h1fc4;
  localparam logic [15:0] IPAS_STEP_A_OFS = 16'h1fc3;
  localparam logic [15:0] IPAS_STEP_B_OFS = 16'h1fc7;
  localparam logic [7:0] IPAS_WINDOW_SEL = 8'h7e;
  // Field positions in a step-control byte
  localparam int IPAS_STEP_DIR_BIT = 4;
  localparam int IPAS_STEP_AMT_W = 4;
  localparam logic [23:0] IPAS_WORD_BYTES = 24'h00_0002;
  localparam logic [4:0] IPAS_STEP_RESET = 5'h00;
  localparam logic [23:0] IPAS_PTR_RESET = 24'h00_0000;

  typedef enum logic [1:0] {
    IPAS_SIZE_BYTE,
    IPAS_SIZE_WORD,
    IPAS_SIZE_NONE
  } ipas_size_t;

  // Register access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic byte_op;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ipas_reg_req_t;

  // Operand-fetch request for one instruction
  typedef struct packed {
    logic end_instr;
    logic use_a;
    logic use_b;
    logic rotate;
  } ipas_instr_t;

  // Memory request issued on behalf of a reference port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ipas_mem_req_t;
endpackage : ipas_pkg

// *** ipas_unit.sv ***
// Index pointer autostep unit: pointers, step bytes and reference ports
//
// Overview of operation
// - Pointers hold 24-bit byte addresses, 16-Mbyte reach
// - Pointer A addresses first source or destination
// - Pointer B addresses second source only
// - Step byte bumps pointer by 0 to 15
// - 3H up 3, 1EH down 14, 12H down 2
// - One step per instruction, at its end
// - Same pointer used twice: old address, one step
// - Port A source/destination, port B source only
// - Port access goes to memory at pointer
// - Each port access moves one 16-bit word
// - Repeat steps pointers on every iteration
// - Rotate variant writes second source one word up
`timescale 1ns/1ns
`default_nettype none
module ipas_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register access from the core; window select gates pointer and step registers, not ports
  input wire logic [7:0] window_select_reg,
  input wire ipas_pkg::ipas_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // Instruction sequencing from the core
  input wire ipas_pkg::ipas_instr_t instr,
  // Memory side of the reference ports
  input wire logic [15:0] mem_rdata,
  output ipas_pkg::ipas_mem_req_t mem_req,
  // Pointer view for the operand fetch logic
  output logic [23:0] ptr_a_out,
  output logic [23:0] ptr_b_out
);
  // ==========================================================
  // State
  logic [23:0] ptr_a_reg;
  logic [23:0] ptr_a_next;
  logic [23:0] ptr_b_reg;
  logic [23:0] ptr_b_next;
  logic [4:0] step_a_reg;
  logic [4:0] step_b_reg;
  logic [15:0] rdata_reg;
  logic hit_reg;
  ipas_pkg::ipas_mem_req_t mem_reg;
  logic [15:0] rot_word_reg;
  logic rot_pend_reg;
  logic [23:0] rot_addr_reg;

  // ==========================================================
  // Decode
  wire logic win_ok = (window_select_reg == ipas_pkg::IPAS_WINDOW_SEL);
  wire logic acc = reg_req.rd | reg_req.wr;
  wire logic [15:0] a = reg_req.addr;
  wire logic sel_pa_lo = win_ok && a == ipas_pkg::IPAS_PTR_A_OFS;
  wire logic sel_pa_hi = win_ok && a == ipas_pkg::IPAS_PTR_A_OFS + 16'h0002;
  wire logic sel_pb_lo = win_ok && a == ipas_pkg::IPAS_PTR_B_OFS;
  wire logic sel_pb_hi = win_ok && a == ipas_pkg::IPAS_PTR_B_OFS + 16'h0002;
  wire logic sel_sa = win_ok && a == ipas_pkg::IPAS_STEP_A_OFS;
  wire logic sel_sb = win_ok && a == ipas_pkg::IPAS_STEP_B_OFS;
  wire logic sel_xa = a == ipas_pkg::IPAS_PORT_A_OFS;
  wire logic sel_xb = a == ipas_pkg::IPAS_PORT_B_OFS;
  // Port B is read-only; a write to it is ignored
  wire logic xb_rd = sel_xb && reg_req.rd;
  wire logic xa_rd = sel_xa && reg_req.rd;
  wire logic xa_wr = sel_xa && reg_req.wr;
  wire logic any_sel = sel_pa_lo | sel_pa_hi | sel_pb_lo | sel_pb_hi | sel_sa | sel_sb
                     | sel_xa | sel_xb;

  // ==========================================================
  // Write strobes and memory activity
  wire logic pa_wr_en = reg_req.wr && (sel_pa_lo || sel_pa_hi);
  wire logic pb_wr_en = reg_req.wr && (sel_pb_lo || sel_pb_hi);
  wire logic sa_wr_en = reg_req.wr && sel_sa;
  wire logic sb_wr_en = reg_req.wr && sel_sb;
  wire logic mem_busy = xa_wr | xa_rd | xb_rd;

  // Step arithmetic: amount in low nibble, bit 4 picks decrement
  function automatic logic [23:0] ipas_step(input logic [23:0] p, input logic [4:0] c);
    logic [23:0] amt;
    amt = {20'h0_0000, c[ipas_pkg::IPAS_STEP_AMT_W-1:0]};
    return c[ipas_pkg::IPAS_STEP_DIR_BIT] ? p - amt : p + amt;
  endfunction : ipas_step

  // Low word and upper byte written separately
  wire logic [23:0] pa_wr = sel_pa_lo ? {ptr_a_reg[23:16], reg_req.wdata}
                          : {reg_req.wdata[7:0], ptr_a_reg[15:0]};
  wire logic [23:0] pb_wr = sel_pb_lo ? {ptr_b_reg[23:16], reg_req.wdata}
                          : {reg_req.wdata[7:0], ptr_b_reg[15:0]};
  wire logic step_now = instr.end_instr;
  wire logic pa_step_en = step_now && instr.use_a;
  wire logic pb_step_en = step_now && instr.use_b;
  // Software write wins over the end-of-instruction step
  assign ptr_a_next = pa_wr_en ? pa_wr
                    : pa_step_en ? ipas_step(ptr_a_reg, step_a_reg)
                    : ptr_a_reg;
  assign ptr_b_next = pb_wr_en ? pb_wr
                    : pb_step_en ? ipas_step(ptr_b_reg, step_b_reg)
                    : ptr_b_reg;

  wire logic [15:0] rd_mux = sel_pa_lo ? ptr_a_reg[15:0]
                           : sel_pa_hi ? {8'h00, ptr_a_reg[23:16]}
                           : sel_pb_lo ? ptr_b_reg[15:0]
                           : sel_pb_hi ? {8'h00, ptr_b_reg[23:16]}
                           : sel_sa ? {11'h000, step_a_reg}
                           : sel_sb ? {11'h000, step_b_reg}
                           : (sel_xa || sel_xb) ? mem_rdata
                           : 16'h0000;

  // Rotate: capture second-source word, store it one word higher
  wire logic rot_cap = instr.rotate && xb_rd;
  wire logic [23:0] rot_addr = ptr_b_reg + ipas_pkg::IPAS_WORD_BYTES;

  // Memory request; pointers are not advanced until instruction end
  ipas_pkg::ipas_mem_req_t mem_next;
  always_comb begin
    mem_next = '0;
    if (xa_wr) begin
      mem_next.wr = 1'b1;
      mem_next.addr = ptr_a_reg;
      mem_next.wdata = reg_req.wdata;
    end else if (xa_rd) begin
      mem_next.rd = 1'b1;
      mem_next.addr = ptr_a_reg;
    end else if (xb_rd) begin
      mem_next.rd = 1'b1;
      mem_next.addr = ptr_b_reg;
    end else if (rot_pend_reg) begin
      mem_next.wr = 1'b1;
      mem_next.addr = rot_addr_reg;
      mem_next.wdata = rot_word_reg;
    end
  end

  // ==========================================================
  // Registers; pointers have no reset, software must load them
  always_ff @(posedge ref_clk) begin
    ptr_a_reg <= ptr_a_next;
  end

  always_ff @(posedge ref_clk) begin
    ptr_b_reg <= ptr_b_next;
  end

  // Step bytes clear to zero, so a pointer never moves by itself
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      step_a_reg <= ipas_pkg::IPAS_STEP_RESET;
    end else if (sa_wr_en) begin
      step_a_reg <= reg_req.wdata[4:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      step_b_reg <= ipas_pkg::IPAS_STEP_RESET;
    end else if (sb_wr_en) begin
      step_b_reg <= reg_req.wdata[4:0];
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (reg_req.rd) begin
      rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hit_reg <= 1'b0;
      mem_reg <= '0;
    end else begin
      hit_reg <= acc && any_sel;
      mem_reg <= mem_next;
    end
  end

  // Address latched at capture: the pointer may step before write-back
  // Limitation: back-to-back rotate reads replace a pending write-back
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rot_word_reg <= 16'h0000;
      rot_addr_reg <= ipas_pkg::IPAS_PTR_RESET;
    end else if (rot_cap) begin
      rot_word_reg <= mem_rdata;
      rot_addr_reg <= rot_addr;
    end
  end

  // Write-back waits for a free memory cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rot_pend_reg <= 1'b0;
    end else begin
      rot_pend_reg <= rot_cap | (rot_pend_reg & mem_busy);
    end
  end

  // Pointer outputs are registered copies; undefined until written
  logic [23:0] pa_out_reg;
  logic [23:0] pb_out_reg;
  always_ff @(posedge ref_clk) begin
    pa_out_reg <= ptr_a_next;
  end

  always_ff @(posedge ref_clk) begin
    pb_out_reg <= ptr_b_next;
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit = hit_reg;
  assign mem_req = mem_reg;
  assign ptr_a_out = pa_out_reg;
  assign ptr_b_out = pb_out_reg;
endmodule : ipas_unit
`default_nettype wire

// *** ipas_unit_properties.sv ***
// Checker for the autostep unit ports
`timescale 1ns/1ns
`default_nettype none
module ipas_chk (
  // Clock, reset, core side
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] window_select_reg,
  input wire ipas_pkg::ipas_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit,
  input wire ipas_pkg::ipas_instr_t instr,
  // Memory and pointer view
  input wire logic [15:0] mem_rdata,
  input wire ipas_pkg::ipas_mem_req_t mem_req,
  input wire logic [23:0] ptr_a_out,
  input wire logic [23:0] ptr_b_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [4:0] step_a_reg;
  wire logic win = window_select_reg == ipas_pkg::IPAS_WINDOW_SEL;
  wire logic [15:0] ad = reg_req.addr;
  wire logic wa = reg_req.wr && ad == ipas_pkg::IPAS_PORT_A_OFS;
  wire logic rb = reg_req.rd && ad == ipas_pkg::IPAS_PORT_B_OFS;
  wire logic [23:0] inc = 24'(step_a_reg[3:0]);
  wire logic [23:0] nxt_a = step_a_reg[4] ? ptr_a_out - inc : ptr_a_out + inc;
  // Pointers are undefined until both halves are written
  logic [1:0] ld_a_reg;
  logic [1:0] ld_b_reg;
  wire logic wr_pa_lo = reg_req.wr && win && ad == ipas_pkg::IPAS_PTR_A_OFS;
  wire logic wr_pa_hi = reg_req.wr && win && ad == ipas_pkg::IPAS_PTR_A_OFS + 16'h0002;
  wire logic wr_pb_lo = reg_req.wr && win && ad == ipas_pkg::IPAS_PTR_B_OFS;
  wire logic wr_pb_hi = reg_req.wr && win && ad == ipas_pkg::IPAS_PTR_B_OFS + 16'h0002;
  wire logic ok_a = &ld_a_reg;
  wire logic ok_b = &ld_b_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ld_a_reg <= 2'b00;
      ld_b_reg <= 2'b00;
    end else begin
      ld_a_reg <= ld_a_reg | {wr_pa_hi, wr_pa_lo};
      ld_b_reg <= ld_b_reg | {wr_pb_hi, wr_pb_lo};
    end
  end
  // Shadow step byte so the next pointer can be predicted
  always_ff @(posedge ref_clk)
    if (reset) step_a_reg <= 5'h00;
    else if (reg_req.wr && win && ad == ipas_pkg::IPAS_STEP_A_OFS) step_a_reg <= reg_req.wdata[4:0];
  a_port_a_write: assert property (wa |=> mem_req.wr && mem_req.addr == $past(ptr_a_out)
    && mem_req.wdata == $past(reg_req.wdata)) else $error("port a write");
  a_port_b_read: assert property (rb |=> mem_req.rd && mem_req.addr == $past(ptr_b_out)
    && reg_rdata == $past(mem_rdata)) else $error("port b read");
  a_port_b_nowrite: assert property (reg_req.wr && ad == ipas_pkg::IPAS_PORT_B_OFS
    && !instr.rotate |=> !mem_req.wr) else $error("port b written");
  a_step_a: assert property (ok_a && instr.end_instr && instr.use_a && !reg_req.wr
    |=> ptr_a_out == $past(nxt_a)) else $error("pointer a step");
  a_ptr_hold: assert property (ok_a && ok_b && !instr.end_instr && !reg_req.wr
    |=> ptr_a_out == $past(ptr_a_out) && ptr_b_out == $past(ptr_b_out))
    else $error("pointer moved");
  a_ptr_load: assert property (reg_req.wr && win && ad == ipas_pkg::IPAS_PTR_A_OFS
    |=> ptr_a_out[15:0] == $past(reg_req.wdata)) else $error("pointer load");
  a_window_gate: assert property (ok_a && reg_req.wr && !win && !instr.end_instr
    |=> $stable(ptr_a_out)) else $error("window ignored");
  a_rotate_back: assert property (rb && instr.rotate |-> ##[1:4] mem_req.wr)
    else $error("no rotate write");
  c_port_a: cover property (wa);
  c_rotate: cover property (rb && instr.rotate);
  c_step: cover property (instr.end_instr && instr.use_a);
endmodule : ipas_chk
bind ipas_unit ipas_chk u_chk (.*);
`default_nettype wire

// *** ipas_unit_tb.sv ***
// Testbench for the index pointer autostep unit
`timescale 1ns/1ns
`default_nettype none
module ipas_unit_tb;
  localparam logic [15:0] PA = ipas_pkg::IPAS_PTR_A_OFS;
  localparam logic [15:0] PB = ipas_pkg::IPAS_PTR_B_OFS;
  localparam logic [15:0] XA = ipas_pkg::IPAS_PORT_A_OFS;
  localparam logic [15:0] XB = ipas_pkg::IPAS_PORT_B_OFS;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] window_select_reg = 8'h7e;
  ipas_pkg::ipas_reg_req_t reg_req = '0;
  ipas_pkg::ipas_instr_t instr = '0;
  ipas_pkg::ipas_mem_req_t mem_req;
  logic [15:0] reg_rdata;
  logic [15:0] mem_rdata;
  logic reg_hit;
  logic [23:0] ptr_a_out;
  logic [23:0] ptr_b_out;
  int failures = 0;
  int checked = 0;
  always #25 ref_clk = ~ref_clk;
  ipas_unit dut (
    .ref_clk(ref_clk),
    .reset(reset),
    .window_select_reg(window_select_reg),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .instr(instr),
    .mem_rdata(mem_rdata),
    .mem_req(mem_req),
    .ptr_a_out(ptr_a_out),
    .ptr_b_out(ptr_b_out)
  );
  ipas_mem_model mem (.addr(reg_req.addr == XA ? ptr_a_out : ptr_b_out), .rdata(mem_rdata));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One access; outputs of it are settled when this returns
  task automatic acc(input logic r, input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [3:0] i);
    @(negedge ref_clk);
    reg_req = '{r, w, 1'b0, a, d};
    instr = i;
    @(negedge ref_clk);
    reg_req = '0;
    instr = '0;
  endtask : acc
  task automatic ld(input logic [15:0] b, input logic [23:0] v, input logic [7:0] s);
    acc(1'b0, 1'b1, b, v[15:0], 4'h0);
    acc(1'b0, 1'b1, b + 16'h0002, {8'h00, v[23:16]}, 4'h0);
    acc(1'b0, 1'b1, b + 16'h0003, {8'h00, s}, 4'h0);
  endtask : ld
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    #2000000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    ld(PA, 24'h65_4321, 8'h03);
    ld(PB, 24'hfe_dcba, 8'h1e);
    chk("ptr_a", 24'h65_4321, ptr_a_out);
    acc(1'b0, 1'b1, XA, 16'h0020, 4'hc);
    chk("mem_addr", 24'h65_4321, mem_req.addr);
    chk("mem_wdata", 24'h00_0020, mem_req.wdata);
    chk("ptr_a", 24'h65_4324, ptr_a_out);
    acc(1'b1, 1'b0, XB, 16'h0000, 4'ha);
    chk("rdata", 24'h00_86e0, reg_rdata);
    chk("ptr_b", 24'hfe_dcac, ptr_b_out);
    acc(1'b0, 1'b0, 16'h0000, 16'h0000, 4'he);
    chk("ptr_a", 24'h65_4327, ptr_a_out);
    chk("ptr_b", 24'hfe_dc9e, ptr_b_out);
    $display("Test ports and steps done");
    window_select_reg = 8'h00;
    acc(1'b0, 1'b1, PA, 16'h0000, 4'h0);
    chk("ptr_a", 24'h65_4327, ptr_a_out);
    window_select_reg = 8'h7e;
    acc(1'b0, 1'b1, XB, 16'h1234, 4'h0);
    chk("mem_wr", 24'h00_0000, mem_req.wr);
    chk("hit", 24'h00_0001, reg_hit);
    acc(1'b1, 1'b0, 16'h0020, 16'h0000, 4'h0);
    chk("hit", 24'h00_0000, reg_hit);
    $display("Test refusals done");
    ld(PA, 24'h11_22fb, 8'h12);
    ld(PB, 24'h44_562e, 8'h12);
    repeat (99) acc(1'b1, 1'b0, XB, 16'h0000, 4'hf);
    chk("ptr_a", 24'h11_2235, ptr_a_out);
    chk("ptr_b", 24'h44_5568, ptr_b_out);
    @(negedge ref_clk);
    chk("rot_wr", 24'h00_0001, mem_req.wr);
    chk("rot_addr", 24'h44_556c, mem_req.addr);
    chk("rot_wdata", 24'h00_0f30, mem_req.wdata);
    $display("Test repeat loop done");
    repeat (4) @(negedge ref_clk);
    end_sim();
  end
endmodule : ipas_unit_tb
`default_nettype wire
